/* File: core/cache_mmu_unit.sv */
// cache tag controller and translation unit, processor and memory ports
// Functional notes
// R01 - pages are always 4 KB; the low 12 address bits pass untranslated
// R02 - takes 32-bit virtual addresses, yields 36-bit physical addresses
// R03 - write-through or buffered copy-back policy chosen by a mode input
// R04 - 12-bit context register, compared in every translation match
// R05 - on buffer hit, matching entry's physical page drives the outputs
// R06 - on buffer miss, hardware walks a three-level table in memory
// R07 - matched entries are checked; violations raise a memory exception
// R08 - 2048 tags of 16 bits for a 64 KB cache of 32-byte lines
// R09 - processor may write and read any tag entry directly
// R10 - tag index is address bits 15..5, compared to the top 16 bits
// R11 - hit is reported only when tag matches and protection passes
// R12 - address and data are captured in registers for pipelined access
// R13 - byte and halfword stores enable only the addressed byte lanes
// R14 - a miss rewrites the tag automatically without processor access
// R15 - after reset all buffer entries and tags are invalid
`timescale 1ns/1ps
module cache_mmu_unit
	import ctmu_pkg::*;
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rstn,
	// processor request
	input  wire logic               cpuReq,
	input  wire logic [VA_W-1:0]    cpuAddr,
	input  wire logic [31:0]        cpuWdata,
	input  wire logic               cpuWrite,
	input  wire logic               cpuExec,
	input  wire logic               cpuSuper,
	input  wire logic [1:0]         cpuSize,     // 0 byte 1 half 2 word
	input  wire logic               cpuTagAcc,   // direct tag access
	// configuration
	input  wire logic [CTX_W-1:0]   ctxIn,
	input  wire logic               ctxLoad,
	input  wire logic               policySel,
	input  wire logic [PA_W-1:0]    tableRoot,
	// processor answer
	output logic                    cpuReady,
	output logic                    cacheHit,
	output logic                    memExc,
	output logic [PA_W-1:0]         physAddr,
	output logic [31:0]             cpuRdata,
	output logic [3:0]              byteEn,
	output logic [31:0]             wdataOut,
	output logic                    copyBack,
	output logic                    busy,
	// main memory table read
	output logic                    memReq,
	output logic [PA_W-1:0]         memAddr,
	input  wire logic               memAck,
	input  wire logic [31:0]        memRdata
);
	ctmu_tlb_if tb ();
	ctmu_state_t      state_q;
	logic [VA_W-1:0]  addr_q;
	logic [31:0]      data_q;
	// access kind of the captured request
	logic             wr_q;        // store
	logic             ex_q;        // instruction fetch
	logic             sup_q;       // supervisor mode
	logic             tagAcc_q;    // direct tag access
	logic [1:0]       size_q;
	logic [CTX_W-1:0] ctx_q;
	logic             policy_q;
	logic [LVL_W-1:0] lvl_q;
	logic [TAG_N-1:0] tagValid_q;
	logic [TAG_W-1:0] tags_q [TAG_N]; // [R08]
	logic [TAG_IW-1:0] idx;
	// lookup results of the captured request
	logic             tagMatch;    // raw tag compare
	logic             protOk;      // rights of matched entry allow it
	logic             walkFault;   // table word is no entry, and no pointer or a pointer at the last level
	logic [3:0]       lanes;
	// table walk addresses, formed apart so the sequencer stays readable
	logic [PA_W-1:0]  firstPtr;    // level-one word address
	logic [PA_W-1:0]  nextPtr;     // word address one level deeper
	logic [5:0]       nextIdx;     // index field of the next level

	// captured request stage so a new access can be presented meanwhile
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			addr_q   <= '0;
			data_q   <= '0;
			wr_q     <= 1'b0;
			ex_q     <= 1'b0;
			sup_q    <= 1'b0;
			size_q   <= '0;
			tagAcc_q <= 1'b0;
		end else if (cpuReq && state_q == CT_IDLE) begin
			addr_q   <= cpuAddr;     // [R12]
			data_q   <= cpuWdata;    // [R12]
			wr_q     <= cpuWrite;
			ex_q     <= cpuExec;
			sup_q    <= cpuSuper;
			size_q   <= cpuSize;
			tagAcc_q <= cpuTagAcc;
		end
	end

	// context and policy registers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctx_q    <= '0;
			policy_q <= CT_WTHRU;
		end else begin
			if (ctxLoad) begin
				ctx_q <= ctxIn;          // [R04]
			end
			policy_q <= policySel;      // [R03]
		end
	end

	// lookup keys come from the captured address, never from the pins,
	// so the processor may already present its next access meanwhile
	assign idx = addr_q[TAG_HI:TAG_LO]; // [R10] [R08]
	assign tb.vpn = addr_q[VA_W-1:PAGE_OFS_W]; // [R01]
	assign tb.ctx = ctx_q;
	// no flush: entries carry their context, so a switch needs none;
	// the cost is that stale contexts linger until round-robin reuse
	assign tb.flush = ctxLoad && 1'b0;
	// refill words come straight from the memory read that returns an entry, at any level
	assign tb.fillPpn = memRdata[PTE_PPN_LO +: PPN_W];
	assign tb.fillAcc = memRdata[PTE_ACC_LO +: 3];
	assign tb.fill = state_q == CT_WAIT && memAck
		&& memRdata[1:0] == ET_PTE;

	// protection: write, user and execute permission of matched entry
	assign protOk = (!wr_q || tb.acc[ACC_WR])
		&& (sup_q || tb.acc[ACC_US])
		&& (!ex_q || tb.acc[ACC_EX]); // [R07]
	assign tagMatch = tagValid_q[idx]
		&& tags_q[idx] == addr_q[VA_W-1:VA_W-TAG_W]; // [R10]
	// a pointer at the last level is as broken as an unknown type
	assign walkFault = memRdata[1:0] != ET_PTE
		&& (memRdata[1:0] != ET_PTD || lvl_q == LVL_LAST);

	// table word addresses: level one from the root, deeper ones from
	// the pointer just read; each word is four bytes, hence the two zeros
	assign nextIdx = lvl_q == 2'h0 ? addr_q[23:18] : addr_q[17:12];
	assign firstPtr = tableRoot
		+ {26'h0, addr_q[VA_W-1 -: 8], 2'h0}; // [R06]
	assign nextPtr = {memRdata[31:PTE_PPN_LO], 12'h0}
		+ {28'h0, nextIdx, 2'h0}; // [R06]

	// byte lanes for partial stores, big-endian lane order
	always_comb begin
		lanes = 4'hf;
		if (size_q == 2'h0) begin
			lanes = 4'h8 >> addr_q[1:0]; // [R13]
		end else if (size_q == 2'h1) begin
			lanes = addr_q[1] ? 4'h3 : 4'hc; // [R13]
		end
	end

	// sequencer: idle lookup, table walk read, wait for memory, answer
	// a successful walk gives no ready; the processor retries and hits,
	// which keeps one answer path and trades a few cycles per miss
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_q <= CT_IDLE;
			lvl_q   <= '0;
			memReq  <= 1'b0;
			memAddr <= '0;
		end else begin
			case (state_q)
				CT_IDLE: begin
					if (cpuReq) begin
						state_q <= CT_DONE;
					end
				end
				CT_DONE: begin
					if (!tagAcc_q && !tb.hit) begin
						state_q <= CT_WALK; // [R06]
						lvl_q   <= '0;
						memAddr <= firstPtr;
					end else begin
						state_q <= CT_IDLE;
					end
				end
				CT_WALK: begin
					memReq  <= 1'b1;
					state_q <= CT_WAIT;
				end
				CT_WAIT: begin
					if (memAck) begin
						memReq <= 1'b0;
						if (memRdata[1:0] == ET_PTE || walkFault) begin
							state_q <= CT_IDLE; // [R06]
						end else begin
							lvl_q   <= lvl_q + 1'b1;
							state_q <= CT_WALK;
							// next level: index fields 23..18, then 17..12
							memAddr <= nextPtr;
						end
					end
				end
				default: state_q <= CT_IDLE;
			endcase
		end
	end

	// tag store: direct writes and automatic refresh on miss
	// a refresh needs a good translation, so a protection fault
	// never replaces a line that a legal access may still want
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tagValid_q <= '0; // [R15]
		end else if (state_q == CT_DONE && tagAcc_q && wr_q) begin
			tagValid_q[idx] <= data_q[TAG_W]; // [R09]
		end else if (state_q == CT_DONE && !tagAcc_q && tb.hit
			&& protOk && !tagMatch) begin
			tagValid_q[idx] <= 1'b1; // [R14]
		end
	end
	// tag words are cleared too, so a direct read of an untouched
	// entry shows zero rather than an unknown value
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < TAG_N; i++) begin
				tags_q[i] <= '0; // [R15]
			end
		end else if (state_q == CT_DONE && tagAcc_q && wr_q) begin
			tags_q[idx] <= data_q[TAG_W-1:0]; // [R09]
		end else if (state_q == CT_DONE && !tagAcc_q && tb.hit
			&& protOk && !tagMatch) begin
			tags_q[idx] <= addr_q[VA_W-1:VA_W-TAG_W]; // [R14]
		end
	end

	// answer to the processor, one-cycle ready pulse per hit, tag access or walk fault
	// hit and exception hold until the next ready, so a slow processor
	// may sample them late; ready itself lasts one cycle only
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cpuReady <= 1'b0;
			cacheHit <= 1'b0;
			memExc   <= 1'b0;
			physAddr <= '0;
			cpuRdata <= '0;
			byteEn   <= '0;
			wdataOut <= '0;
			copyBack <= 1'b0;
			busy     <= 1'b0;
		end else begin
			busy     <= state_q != CT_IDLE || cpuReq;
			cpuReady <= 1'b0;
			if (state_q == CT_DONE && tagAcc_q) begin
				cpuReady <= 1'b1;
				cacheHit <= 1'b0;
				memExc   <= 1'b0;
				cpuRdata <= {15'h0, tagValid_q[idx], tags_q[idx]}; // [R09]
			end else if (state_q == CT_DONE && tb.hit) begin
				cpuReady <= 1'b1;
				physAddr <= {tb.ppn, addr_q[PAGE_OFS_W-1:0]}; // [R05] [R02]
				memExc   <= !protOk;                        // [R07]
				cacheHit <= tagMatch && protOk;             // [R11]
				byteEn   <= wr_q && protOk ? lanes : 4'h0;   // [R13]
				wdataOut <= data_q;
				copyBack <= policy_q == CT_CBACK;           // [R03]
			end else if (state_q == CT_WAIT && memAck && walkFault) begin
				cpuReady <= 1'b1;
				cacheHit <= 1'b0;
				memExc   <= 1'b1;                           // [R07]
			end
		end
	end

	// walk success returns to idle; processor retries and now hits
	// the buffer refills from the same memory word the walk ends on
	ctmu_tlb uTlb (
		.mclk (mclk),
		.rstn (rstn),
		.tb   (tb)
	);
endmodule

/* File: core/ctmu_tlb.sv */
// fully associative translation buffer with round-robin refill
`timescale 1ns/1ps
module ctmu_tlb
	import ctmu_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// lookup and refill
	ctmu_tlb_if.tlb   tb
);
	logic [TLB_N-1:0] valid_q;
	logic [VPN_W-1:0] vpn_q [TLB_N];
	logic [CTX_W-1:0] ctx_q [TLB_N];
	logic [PPN_W-1:0] ppn_q [TLB_N];
	logic [2:0]       acc_q [TLB_N];
	logic [TLB_IW-1:0] vict_q;
	logic [TLB_N-1:0] match;

	// match on page number and context together
	genvar g;
	generate
		for (g = 0; g < TLB_N; g++) begin : gEnt
			assign match[g] = valid_q[g] && vpn_q[g] == tb.vpn
				&& ctx_q[g] == tb.ctx; // [R04]
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					valid_q[g] <= 1'b0; // [R15]
				end else if (tb.flush) begin
					valid_q[g] <= 1'b0;
				end else if (tb.fill && vict_q == TLB_IW'(g)) begin
					valid_q[g] <= 1'b1;
				end
			end
			always_ff @(posedge mclk) begin
				if (tb.fill && vict_q == TLB_IW'(g)) begin
					vpn_q[g] <= tb.vpn;
					ctx_q[g] <= tb.ctx;
					ppn_q[g] <= tb.fillPpn;
					acc_q[g] <= tb.fillAcc;
				end
			end
		end
	endgenerate

	// one-hot select; entries never duplicate since fill follows a miss
	always_comb begin
		tb.hit = |match;
		tb.ppn = '0;
		tb.acc = '0;
		for (int i = 0; i < TLB_N; i++) begin
			if (match[i]) begin
				tb.ppn = tb.ppn | ppn_q[i];
				tb.acc = tb.acc | acc_q[i];
			end
		end
	end

	// victim pointer advances on each refill
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			vict_q <= '0;
		end else if (tb.fill) begin
			vict_q <= vict_q + 1'b1;
		end
	end
endmodule

/* File: pkg/ctmu_pkg.sv */
// shared constants and types of the cache tag and translation unit
package ctmu_pkg;
	localparam int VA_W        = 32;
	localparam int PA_W        = 36;
	localparam int PAGE_OFS_W  = 12;          // fixed 4 KB page
	localparam int VPN_W       = VA_W - PAGE_OFS_W;
	localparam int PPN_W       = PA_W - PAGE_OFS_W;
	localparam int CTX_W       = 12;          // 4096 contexts
	localparam int TLB_N       = 8;
	localparam int TLB_IW      = 3;
	localparam int TAG_N       = 2048;
	localparam int TAG_IW      = 11;
	localparam int TAG_LO      = 5;           // 32-byte line
	localparam int TAG_HI      = 15;
	localparam int TAG_W       = 16;
	localparam int LVL_W       = 2;
	localparam logic [1:0] LVL_LAST = 2'h2;   // three levels: 0,1,2
	// page table entry layout: ppn[31:8], acc[4:2], type[1:0]
	localparam int PTE_PPN_LO  = 8;
	localparam int PTE_ACC_LO  = 2;
	localparam logic [1:0] ET_PTD = 2'h1;
	localparam logic [1:0] ET_PTE = 2'h2;
	// access bits: 0 write allowed, 1 user allowed, 2 execute allowed
	localparam int ACC_WR      = 0;
	localparam int ACC_US      = 1;
	localparam int ACC_EX      = 2;
	typedef enum logic [1:0] {
		CT_IDLE  = 2'b00,
		CT_WALK  = 2'b01,
		CT_WAIT  = 2'b10,
		CT_DONE  = 2'b11
	} ctmu_state_t;
	typedef enum logic [0:0] {
		CT_WTHRU = 1'b0,
		CT_CBACK = 1'b1
	} ctmu_policy_t;
endpackage

/* File: pkg/ctmu_tlb_if.sv */
// lookup request and answer between top and translation buffer
`timescale 1ns/1ps
interface ctmu_tlb_if;
	import ctmu_pkg::*;
	logic [VPN_W-1:0] vpn;
	logic [CTX_W-1:0] ctx;
	logic             hit;
	logic [PPN_W-1:0] ppn;
	logic [2:0]       acc;
	logic             fill;
	logic [PPN_W-1:0] fillPpn;
	logic [2:0]       fillAcc;
	logic             flush;
	modport top (output vpn, ctx, fill, fillPpn, fillAcc, flush,
		input hit, ppn, acc);
	modport tlb (input vpn, ctx, fill, fillPpn, fillAcc, flush,
		output hit, ppn, acc);
endinterface

/* File: verification/ctmu_mem_model.sv */
// main memory answering the table reads of a walk
`timescale 1ns/1ps
module ctmu_mem_model
	import ctmu_pkg::*;
(
	// clock and table read port
	input wire logic             mclk,
	input wire logic             memReq,
	output logic                 memAck = 1'b0,
	output logic [31:0]          memRdata = 32'h0,
	// behaviour chosen by the bench
	input wire logic [PPN_W-1:0] ppn,
	input wire logic [2:0]       acc,
	input wire logic             fault,
	input wire logic [3:0]       dly
);
	int waitN = 0;
	int lvl = 0;
	// data toggles between answers so stale words are never trusted
	always @(posedge mclk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck) begin
			if (waitN >= dly) begin
				memAck <= 1'b1;
				waitN <= 0;
				// two pointers then an entry; a fault ends the walk
				if (fault) begin
					memRdata <= 32'h0;
					lvl <= 0;
				end else if (lvl < 2) begin
					memRdata <= {30'h0, ET_PTD};
					lvl <= lvl + 1;
				end else begin
					memRdata <= {ppn, 3'h0, acc, ET_PTE};
					lvl <= 0;
				end
			end else
				waitN <= waitN + 1;
		end
	end
endmodule

/* File: verification/ctmu_props.sv */
// assertions watching the cache tag and translation unit ports
`timescale 1ns/1ps
module ctmu_props
	import ctmu_pkg::*;
(
	// watched ports
	input wire logic            mclk,
	input wire logic            rstn,
	input wire logic            cpuReq,
	input wire logic [VA_W-1:0] cpuAddr,
	input wire logic            cpuWrite,
	input wire logic [1:0]      cpuSize,
	input wire logic            cpuTagAcc,
	input wire logic            cpuReady,
	input wire logic            cacheHit,
	input wire logic            memExc,
	input wire logic [PA_W-1:0] physAddr,
	input wire logic [3:0]      byteEn,
	input wire logic            busy,
	input wire logic            memReq,
	input wire logic [PA_W-1:0] memAddr,
	input wire logic            memAck
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// latency and walk handshake
	a_tag_latency: assert property (cpuReq && !busy && cpuTagAcc |=> busy ##1 cpuReady)
		else $error("tag access answer late");
	a_ready_pulse: assert property (cpuReady |=> !cpuReady)
		else $error("ready longer than one cycle");
	a_walk_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
		else $error("table read dropped early");
	a_walk_busy: assert property (memReq |-> busy)
		else $error("table read while idle");
	// result qualification
	a_exc_at_ready: assert property (!$stable(memExc) |-> cpuReady)
		else $error("exception moved without ready");
	a_hit_prot: assert property (cacheHit |-> !memExc)
		else $error("hit reported with exception");
	a_page_offset: assert property (cpuReady && cacheHit
		|-> physAddr[11:0] == $past(cpuAddr[11:0], 2))
		else $error("page offset altered");
	// lanes follow size and low address bits of the store
	a_store_lanes: assert property (cpuReady && cacheHit && $past(cpuWrite, 2)
		|-> byteEn == ($past(cpuSize, 2) == 2'h2 ? 4'hf :
		$past(cpuSize, 2) == 2'h1 ? ($past(cpuAddr[1], 2) ? 4'h3 : 4'hc) :
		4'h8 >> $past(cpuAddr[1:0], 2)))
		else $error("store lanes wrong");
	a_reset_idle: assert property ($rose(rstn) |-> !busy && !memReq && !cacheHit)
		else $error("not quiet after reset");
	// main scenarios reached
	c_hit: cover property (cpuReady && cacheHit);
	c_exc: cover property (cpuReady && memExc);
	c_walk: cover property (memReq && memAck);
endmodule
bind cache_mmu_unit ctmu_props i_ctmu_props (.mclk, .rstn, .cpuReq,
	.cpuAddr, .cpuWrite, .cpuSize, .cpuTagAcc, .cpuReady, .cacheHit,
	.memExc, .physAddr, .byteEn, .busy, .memReq, .memAddr, .memAck);

/* File: verification/tb.sv */
// self-checking bench of the cache tag and translation unit
`timescale 1ns/1ps
module tb
	import ctmu_pkg::*;
;
	logic mclk = 1'b0, rstn = 1'b0;
	logic cpuReq, cpuWrite, cpuExec, cpuSuper, cpuTagAcc, ctxLoad, policySel;
	logic [31:0] cpuAddr, cpuWdata, cpuRdata, wdataOut, memRdata;
	logic [1:0] cpuSize;
	logic [CTX_W-1:0] ctxIn, ctxM;
	logic [PA_W-1:0] tableRoot, physAddr, memAddr;
	logic cpuReady, cacheHit, memExc, copyBack, busy, memReq, memAck, mFault;
	logic [3:0] byteEn, mDly;
	logic [PPN_W-1:0] mPpn;
	logic [2:0] mAcc;
	logic [26:0] tlbM [int unsigned];
	logic [16:0] tagM [TAG_N];
	int failCount = 0, compares = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	cache_mmu_unit i_cache_mmu_unit (.mclk, .rstn, .cpuReq, .cpuAddr,
		.cpuWdata, .cpuWrite, .cpuExec, .cpuSuper, .cpuSize, .cpuTagAcc,
		.ctxIn, .ctxLoad, .policySel, .tableRoot, .cpuReady, .cacheHit,
		.memExc, .physAddr, .cpuRdata, .byteEn, .wdataOut, .copyBack, .busy,
		.memReq, .memAddr, .memAck, .memRdata);
	ctmu_mem_model i_ctmu_mem_model (.mclk, .memReq, .memAck, .memRdata,
		.ppn(mPpn), .acc(mAcc), .fault(mFault), .dly(mDly));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrapUp();
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// f is {tag access, supervisor, fetch, write}; model decides the outcome
	task automatic op(input logic [31:0] va, input logic [3:0] f,
			input logic [1:0] sz, input logic [31:0] wd);
		logic rdy, prot, hit, pol;
		logic [26:0] e;
		logic [31:0] key;
		logic [10:0] ix;
		key = {ctxM, va[31:12]};
		ix = va[15:5];
		rdy = 1'b0;
		pol = 1'($urandom);
		while (busy === 1'b1) @(posedge mclk);
		@(posedge mclk);
		{cpuTagAcc, cpuSuper, cpuExec, cpuWrite} <= f;
		{cpuAddr, cpuSize, cpuWdata, cpuReq} <= {va, sz, wd, 1'b1};
		mDly <= 4'($urandom_range(0, 4));
		policySel <= pol;
		@(posedge mclk);
		cpuReq <= 1'b0;
		for (int k = 0; k < 60 && !rdy; k++) begin
			@(posedge mclk);
			#1;
			rdy = cpuReady === 1'b1;
			if (k > 1 && busy !== 1'b1 && !rdy) break;
		end
		if (f[3]) begin
			chk(rdy, 1'b1);
			if (f[0]) tagM[ix] = wd[16:0];
			else chk(cpuRdata, {15'h0, tagM[ix]});
		end else if (!tlbM.exists(key)) begin
			chk(rdy, mFault);
			if (mFault) chk(memExc, 1'b1);
			else tlbM[key] = {mAcc, mPpn};
		end else begin
			e = tlbM[key];
			prot = (f[0] && !e[24]) || (!f[2] && !e[25]) || (f[1] && !e[26]);
			hit = !prot && tagM[ix] === {1'b1, va[31:16]};
			chk({rdy, memExc, cacheHit}, {1'b1, prot, hit});
			chk(copyBack, pol);
			if (!prot) chk(physAddr, {e[23:0], va[11:0]});
			if (!prot && !hit) tagM[ix] = {1'b1, va[31:16]};
			if (hit && f[0]) begin
				chk(byteEn, sz == 2 ? 4'hf : sz == 1 ? (va[1] ? 4'h3 : 4'hc) :
					4'h8 >> va[1:0]);
				chk(wdataOut, wd);
			end
		end
	endtask
	task automatic setCtx(input logic [CTX_W-1:0] c);
		@(posedge mclk);
		{ctxIn, ctxLoad} <= {c, 1'b1};
		@(posedge mclk);
		ctxLoad <= 1'b0;
		ctxM = c;
	endtask
	// run ceiling well above the expected length
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failCount++;
			wrapUp();
		end
	end
	initial begin
		logic [31:0] a;
		void'($urandom(32'h91849ad3));
		{cpuReq, cpuWrite, cpuExec, cpuSuper, cpuTagAcc, ctxLoad} = 6'h0;
		{cpuAddr, cpuWdata, cpuSize, ctxIn, ctxM, policySel} = '0;
		{mPpn, mAcc, mFault, mDly} = '0;
		tableRoot = 36'h000010000;
		foreach (tagM[j]) tagM[j] = 17'h0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		// untouched tags read invalid, direct writes read back
		for (int i = 0; i < 6; i++) begin
			a = $urandom;
			if (i > 2) op(a, 4'b1001, 2'h2, $urandom);
			op(a, 4'b1000, 2'h2, 32'h0);
		end
		// walk, tag refresh on miss, then hit; stale tag forces refill
		a = $urandom;
		{mPpn, mAcc} = {24'($urandom), 3'h7};
		repeat (3) op(a, 4'b0100, 2'h2, 32'h0);
		op(a, 4'b1000, 2'h2, 32'h0);
		op(a, 4'b1001, 2'h2, {15'h0, 1'b1, ~a[31:16]});
		repeat (2) op(a, 4'b0100, 2'h2, 32'h0);
		// each byte, both halves and the word of a hitting line
		for (int i = 0; i < 7; i++)
			op({a[31:2], 2'(i < 4 ? i : i == 5 ? 2 : 0)}, 4'b0101,
				2'(i < 4 ? 0 : i < 6 ? 1 : 2), $urandom);
		// pages with random rights met by random access kinds
		for (int i = 0; i < 4; i++) begin
			{cpuWdata, mPpn, mAcc} <= {$urandom, 24'($urandom), 3'($urandom)};
			a = $urandom;
			repeat (6) op(a, {1'b0, 3'($urandom)}, 2'h2, $urandom);
		end
		// a broken table entry ends the walk with an exception
		mFault = 1'b1;
		op($urandom, 4'b0100, 2'h2, 32'h0);
		mFault = 1'b0;
		// a second context maps the same page elsewhere
		mPpn = 24'($urandom);
		setCtx(12'h5a3);
		repeat (2) op(a, 4'b0100, 2'h2, 32'h0);
		setCtx(12'h000);
		op(a, 4'b0100, 2'h2, 32'h0);
		wrapUp();
	end
endmodule
